//--- design/gpp_params.svh
// Purpose: register offsets, reset values and bus codes of the gpio port
// Assumes: 12-bit byte address, 32-bit AXI4-Lite data
// Notes:   masked data window occupies 12'h000..12'h3fc
`ifndef GPP_PARAMS_SVH
`define GPP_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define GPP_OFF_DIR    12'h400
`define GPP_OFF_SENSE  12'h404
`define GPP_OFF_BOTH   12'h408
`define GPP_OFF_EVHI   12'h40c
`define GPP_OFF_IEN    12'h410
`define GPP_OFF_RAW    12'h414
`define GPP_OFF_MSK    12'h418
`define GPP_OFF_ICLR   12'h41c
`define GPP_OFF_PSEL   12'h420
`define GPP_OFF_DRV    12'h500
`define GPP_OFF_SLEW   12'h504
`define GPP_OFF_ODRN   12'h508
`define GPP_OFF_PUP    12'h50c
`define GPP_OFF_PDN    12'h510
`define GPP_OFF_ADC    12'h514

// ****************************************
// window and reset values
// ****************************************
`define GPP_DATA_WIN   2'h0
`define GPP_RST_PINS   8'h00
`define GPP_RST_PUP    8'h00

// ****************************************
// bus answer codes
// ****************************************
`define GPP_RESP_OKAY  2'h0
`define GPP_RESP_SLVE  2'h2

`endif

//--- design/gpp_pkg.sv
// Purpose: types shared by the gpio port and its pin cell
// Assumes: nothing beyond the params header
// Notes:   drive code 2'h3 is illegal and never stored
package gpp_pkg;

  typedef enum logic [1:0] {
    gpp_drv_2ma,
    gpp_drv_4ma,
    gpp_drv_8ma,
    gpp_drv_bad
  } gpp_drive_e;

  typedef struct packed {
    logic dir_out;
    logic periph;
    logic open_drain;
    logic level_sense;
    logic both_edges;
    logic event_high;
  } gpp_pin_cfg_s;

  typedef struct packed {
    gpp_drive_e drive;
    logic       slew;
    logic       pull_up;
    logic       pull_down;
  } gpp_pad_s;

endpackage

//--- design/gpp_pin_cell.sv
// Purpose: one pin: input synchroniser, condition detect, pad drive
// Assumes: pad_in_i is asynchronous to clk_i
// Notes:   all outputs registered
`timescale 1ns/1ps
module gpp_pin_cell (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 pad_in_i,
  input  wire gpp_pkg::gpp_pin_cfg_s cfg_i,
  input  wire logic                 out_val_i,
  input  wire logic                 periph_out_i,
  input  wire logic                 periph_oe_i,
  output logic                      level_o,
  output logic                      event_o,
  output logic                      pad_out_o,
  output logic                      pad_oe_n_o
);

  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic rise;
  logic fall;
  logic event_d;
  logic drive_en;
  logic drive_val;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q  <= 1'b0;
    end else begin
      sync1_q <= pad_in_i;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;

  always_comb begin
    if (cfg_i.level_sense) begin
      event_d = cfg_i.event_high ? sync2_q : ~sync2_q;
    end else if (cfg_i.both_edges) begin
      event_d = rise | fall;
    end else begin
      event_d = cfg_i.event_high ? rise : fall;
    end
  end

  assign drive_en  = cfg_i.periph ? periph_oe_i : cfg_i.dir_out;
  assign drive_val = cfg_i.periph ? periph_out_i : out_val_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_o    <= 1'b0;
      event_o    <= 1'b0;
      pad_out_o  <= 1'b0;
      pad_oe_n_o <= 1'b1;
    end else begin
      level_o <= sync2_q;
      event_o <= event_d;
      if (cfg_i.open_drain) begin
        pad_out_o  <= 1'b0;
        pad_oe_n_o <= ~(drive_en & ~drive_val);
      end else begin
        pad_out_o  <= drive_val;
        pad_oe_n_o <= ~drive_en;
      end
    end
  end

endmodule // gpp_pin_cell

//--- design/gpp_port.sv
// Purpose: eight-pin gpio port with AXI4-Lite register slave
// Assumes: single clock clk_i, synchronous active-high reset rst_i
// Notes:   data window uses address bits [9:2] as the pin mask
//
// Behaviour
// - up to eight pins; mask bit n and index n mean pin n
// - per-pin input or output direction, all inputs after reset
// - input interrupt on high, low, rising, falling or both edges
// - per-pin drive 2, 4 or 8 mA to pad, reset 2 mA
// - slew control reaches pad only with 8 mA drive
// - weak pull-up and pull-down enables, reset off or variant pull-up
// - per-pin open-drain, reset to push-pull
// - per-pin port or peripheral control, reset port-controlled
// - data read returns only the pins selected by the mask
// - data write changes selected pins together, others untouched
// - pin mask taken from address bits of one access
// - per-pin ADC trigger enable, off removes the trigger
// - ADC trigger and interrupt work independently
// - hardware control mode: peripheral drives and senses the pin
// - only enabled sources reach the interrupt output
// - raw and masked status readable, selected sources clearable
`timescale 1ns/1ps
`include "gpp_params.svh"
module gpp_port #(
  parameter int          NUM_PINS  = 8,
  parameter logic [7:0]  PUP_RESET = `GPP_RST_PUP
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [11:0]                   s_axi_awaddr_i,
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [31:0]                   s_axi_wdata_i,
  input  wire logic [3:0]                    s_axi_wstrb_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  output logic [1:0]                         s_axi_bresp_o,
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  input  wire logic [11:0]                   s_axi_araddr_i,
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  output logic [31:0]                        s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  input  wire logic [NUM_PINS-1:0]           pad_in_i,
  output logic [NUM_PINS-1:0]                pad_out_o,
  output logic [NUM_PINS-1:0]                pad_oe_n_o,
  output gpp_pkg::gpp_pad_s [NUM_PINS-1:0]   pad_cfg_o,
  input  wire logic [NUM_PINS-1:0]           periph_out_i,
  input  wire logic [NUM_PINS-1:0]           periph_oe_i,
  output logic [NUM_PINS-1:0]                periph_in_o,
  output logic [NUM_PINS-1:0]                adc_trig_o,
  output logic                               irq_o
);

  // ****************************************
  // state
  // ****************************************
  logic [11:0]              aw_addr_q;
  logic                     aw_full_q;
  logic [31:0]              w_data_q;
  logic [3:0]               w_strb_q;
  logic                     w_full_q;
  logic                     awready_q;
  logic                     wready_q;
  logic                     bvalid_q;
  logic [1:0]               bresp_q;
  logic                     arready_q;
  logic                     rvalid_q;
  logic [1:0]               rresp_q;
  logic [31:0]              rdata_q;
  logic [NUM_PINS-1:0]      data_q;
  logic [NUM_PINS-1:0]      dir_q;
  logic [NUM_PINS-1:0]      psel_q;
  logic [NUM_PINS-1:0]      sense_q;
  logic [NUM_PINS-1:0]      both_q;
  logic [NUM_PINS-1:0]      evhi_q;
  logic [NUM_PINS-1:0]      ien_q;
  logic [NUM_PINS-1:0]      raw_q;
  logic [NUM_PINS-1:0]      raw_d;
  logic [NUM_PINS-1:0]      slew_q;
  logic [NUM_PINS-1:0]      odrn_q;
  logic [NUM_PINS-1:0]      pup_q;
  logic [NUM_PINS-1:0]      pdn_q;
  logic [NUM_PINS-1:0]      adc_en_q;
  gpp_pkg::gpp_drive_e      drv_q [NUM_PINS];
  logic                     irq_q;
  logic [NUM_PINS-1:0]      adc_trig_q;
  gpp_pkg::gpp_pad_s [NUM_PINS-1:0] pad_cfg_q;

  logic                     wr_go;
  logic                     wr_ok;
  logic                     wr_lane0;
  logic                     wr_data_win;
  logic [NUM_PINS-1:0]      wr_mask;
  logic [NUM_PINS-1:0]      wr_byte;
  logic [NUM_PINS-1:0]      clr_bits;
  logic                     rd_go;
  logic                     rd_ok;
  logic [31:0]              rd_word;
  logic [NUM_PINS-1:0]      rd_mask;
  logic [NUM_PINS-1:0]      level;
  logic [NUM_PINS-1:0]      event_p;
  logic [NUM_PINS-1:0]      pin_view;

  // ****************************************
  // per-pin cells
  // ****************************************
  for (genvar n = 0; n < NUM_PINS; n++) begin : g_pin
    gpp_pkg::gpp_pin_cfg_s cfg;
    assign cfg.dir_out     = dir_q[n];
    assign cfg.periph      = psel_q[n];
    assign cfg.open_drain  = odrn_q[n];
    assign cfg.level_sense = sense_q[n];
    assign cfg.both_edges  = both_q[n];
    assign cfg.event_high  = evhi_q[n];

    gpp_pin_cell u_cell (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .pad_in_i     (pad_in_i[n]),
      .cfg_i        (cfg),
      .out_val_i    (data_q[n]),
      .periph_out_i (periph_out_i[n]),
      .periph_oe_i  (periph_oe_i[n]),
      .level_o      (level[n]),
      .event_o      (event_p[n]),
      .pad_out_o    (pad_out_o[n]),
      .pad_oe_n_o   (pad_oe_n_o[n])
    );
  end

  assign periph_in_o = level;

  // ****************************************
  // write channel
  // ****************************************
  assign wr_go       = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_lane0    = w_strb_q[0];
  assign wr_byte     = w_data_q[NUM_PINS-1:0];
  assign wr_data_win = (aw_addr_q[11:10] == `GPP_DATA_WIN);
  assign wr_mask     = aw_addr_q[NUM_PINS+1:2];

  always_comb begin
    unique case ({aw_addr_q[11:2], 2'h0})
      `GPP_OFF_DIR, `GPP_OFF_SENSE, `GPP_OFF_BOTH, `GPP_OFF_EVHI,
      `GPP_OFF_IEN, `GPP_OFF_ICLR, `GPP_OFF_PSEL, `GPP_OFF_DRV,
      `GPP_OFF_SLEW, `GPP_OFF_ODRN, `GPP_OFF_PUP, `GPP_OFF_PDN,
      `GPP_OFF_ADC, `GPP_OFF_RAW, `GPP_OFF_MSK: wr_ok = 1'b1;
      default: wr_ok = wr_data_win;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (s_axi_awvalid_i && awready_q) begin
      awready_q <= 1'b0;
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr_i;
    end else begin
      if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      awready_q <= ~aw_full_q & ~bvalid_q & ~wr_go;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid_i && wready_q) begin
      wready_q <= 1'b0;
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata_i;
      w_strb_q <= s_axi_wstrb_i;
    end else begin
      if (wr_go) begin
        w_full_q <= 1'b0;
      end
      wready_q <= ~w_full_q & ~bvalid_q & ~wr_go;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `GPP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_ok ? `GPP_RESP_OKAY : `GPP_RESP_SLVE;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_q    <= `GPP_RST_PINS;
      psel_q   <= `GPP_RST_PINS;
      odrn_q   <= `GPP_RST_PINS;
      sense_q  <= `GPP_RST_PINS;
      both_q   <= `GPP_RST_PINS;
      evhi_q   <= `GPP_RST_PINS;
      ien_q    <= `GPP_RST_PINS;
      slew_q   <= `GPP_RST_PINS;
      pup_q    <= PUP_RESET[NUM_PINS-1:0];
      pdn_q    <= `GPP_RST_PINS;
      adc_en_q <= `GPP_RST_PINS;
    end else if (wr_go && wr_lane0) begin
      unique case ({aw_addr_q[11:2], 2'h0})
        `GPP_OFF_DIR:   dir_q    <= wr_byte;
        `GPP_OFF_PSEL:  psel_q   <= wr_byte;
        `GPP_OFF_ODRN:  odrn_q   <= wr_byte;
        `GPP_OFF_SENSE: sense_q  <= wr_byte;
        `GPP_OFF_BOTH:  both_q   <= wr_byte;
        `GPP_OFF_EVHI:  evhi_q   <= wr_byte;
        `GPP_OFF_IEN:   ien_q    <= wr_byte;
        `GPP_OFF_SLEW:  slew_q   <= wr_byte;
        `GPP_OFF_PUP:   pup_q    <= wr_byte;
        `GPP_OFF_PDN:   pdn_q    <= wr_byte;
        `GPP_OFF_ADC:   adc_en_q <= wr_byte;
        default: ;
      endcase
    end
  end

  // drive select, illegal code keeps old value
  for (genvar n = 0; n < NUM_PINS; n++) begin : g_drv
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        drv_q[n] <= gpp_pkg::gpp_drv_2ma;
      end else if (wr_go && ({aw_addr_q[11:2], 2'h0} == `GPP_OFF_DRV) &&
                   w_strb_q[n/4] && (w_data_q[2*n+:2] != 2'h3)) begin
        drv_q[n] <= gpp_pkg::gpp_drive_e'(w_data_q[2*n+:2]);
      end
    end
  end

  // ****************************************
  // output data
  // ****************************************
  // selected pins updated at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_q <= `GPP_RST_PINS;
    end else if (wr_go && wr_lane0 && wr_data_win) begin
      data_q <= (data_q & ~wr_mask) | (wr_byte & wr_mask);
    end
  end

  // ****************************************
  // interrupt status
  // ****************************************
  assign clr_bits = (wr_go && wr_lane0 &&
                     ({aw_addr_q[11:2], 2'h0} == `GPP_OFF_ICLR)) ?
                    wr_byte : {NUM_PINS{1'b0}};

  assign raw_d = (raw_q & ~clr_bits) | event_p;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_q <= `GPP_RST_PINS;
    end else begin
      raw_q <= raw_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(raw_q & ien_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_trig_q <= `GPP_RST_PINS;
    end else begin
      adc_trig_q <= event_p & adc_en_q;
    end
  end

  // ****************************************
  // pad configuration
  // ****************************************
  for (genvar n = 0; n < NUM_PINS; n++) begin : g_pad
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pad_cfg_q[n] <= '{gpp_pkg::gpp_drv_2ma, 1'b0, PUP_RESET[n], 1'b0};
      end else begin
        pad_cfg_q[n].drive     <= drv_q[n];
        pad_cfg_q[n].slew      <= slew_q[n] &
                                  (drv_q[n] == gpp_pkg::gpp_drv_8ma);
        pad_cfg_q[n].pull_up   <= pup_q[n];
        pad_cfg_q[n].pull_down <= pdn_q[n];
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  assign rd_go    = s_axi_arvalid_i & arready_q;
  // mask bit n is pin n
  assign rd_mask  = s_axi_araddr_i[NUM_PINS+1:2];
  assign pin_view = (dir_q & ~psel_q & data_q) | (~(dir_q & ~psel_q) & level);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr_i[11:10] == `GPP_DATA_WIN) begin
      rd_word[NUM_PINS-1:0] = pin_view & rd_mask;
    end else begin
      unique case ({s_axi_araddr_i[11:2], 2'h0})
        `GPP_OFF_DIR:   rd_word[NUM_PINS-1:0] = dir_q;
        `GPP_OFF_PSEL:  rd_word[NUM_PINS-1:0] = psel_q;
        `GPP_OFF_SENSE: rd_word[NUM_PINS-1:0] = sense_q;
        `GPP_OFF_BOTH:  rd_word[NUM_PINS-1:0] = both_q;
        `GPP_OFF_EVHI:  rd_word[NUM_PINS-1:0] = evhi_q;
        `GPP_OFF_IEN:   rd_word[NUM_PINS-1:0] = ien_q;
        `GPP_OFF_RAW:   rd_word[NUM_PINS-1:0] = raw_q;
        `GPP_OFF_MSK:   rd_word[NUM_PINS-1:0] = raw_q & ien_q;
        `GPP_OFF_ICLR:  rd_word = 32'h0000_0000;
        `GPP_OFF_SLEW:  rd_word[NUM_PINS-1:0] = slew_q;
        `GPP_OFF_ODRN:  rd_word[NUM_PINS-1:0] = odrn_q;
        `GPP_OFF_PUP:   rd_word[NUM_PINS-1:0] = pup_q;
        `GPP_OFF_PDN:   rd_word[NUM_PINS-1:0] = pdn_q;
        `GPP_OFF_ADC:   rd_word[NUM_PINS-1:0] = adc_en_q;
        `GPP_OFF_DRV: begin
          for (int n = 0; n < NUM_PINS; n++) begin
            rd_word[2*n+:2] = drv_q[n];
          end
        end
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `GPP_RESP_OKAY;
    end else if (rd_go) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word;
      rresp_q   <= rd_ok ? `GPP_RESP_OKAY : `GPP_RESP_SLVE;
    end else if (rvalid_q) begin
      rvalid_q  <= ~s_axi_rready_i;
    end else begin
      arready_q <= 1'b1;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign pad_cfg_o       = pad_cfg_q;
  assign adc_trig_o      = adc_trig_q;
  assign irq_o           = irq_q;

endmodule // gpp_port

//--- testbench/gpp_pin_model.sv
// Purpose: board and pad model for the gpio port pins
// Assumes: the board drives only pins set in ext_en_i
// Notes:   undriven pins with no pull toggle each cycle
`timescale 1ns/1ps
module gpp_pin_model (
  input  wire logic                    clk_i,
  input  wire logic [7:0]              pad_out_i,
  input  wire logic [7:0]              pad_oe_n_i,
  input  wire gpp_pkg::gpp_pad_s [7:0] pad_cfg_i,
  input  wire logic [7:0]              ext_en_i,
  input  wire logic [7:0]              ext_val_i,
  output logic [7:0]                   pad_in_o
);
  logic [7:0] float_q = 8'h00;
  always_ff @(posedge clk_i) begin
    float_q <= ~pad_in_o;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in_o[i] = !pad_oe_n_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] :
                    pad_cfg_i[i].pull_up ? 1'b1 : pad_cfg_i[i].pull_down ? 1'b0 : float_q[i];
    end
  end
endmodule // gpp_pin_model

//--- testbench/gpp_port_asserts.sv
// Purpose: bus, pad and sync checks on the gpio port
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to gpp_port at the foot of this file
`timescale 1ns/1ps
module gpp_port_asserts #(
  parameter int         NUM_PINS  = 8,
  parameter logic [7:0] PUP_RESET = 8'h00
) (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        s_axi_awvalid_i,
  input wire logic                        s_axi_awready_o,
  input wire logic                        s_axi_wvalid_i,
  input wire logic                        s_axi_wready_o,
  input wire logic [1:0]                  s_axi_bresp_o,
  input wire logic                        s_axi_bvalid_o,
  input wire logic                        s_axi_bready_i,
  input wire logic                        s_axi_arvalid_i,
  input wire logic                        s_axi_arready_o,
  input wire logic [31:0]                 s_axi_rdata_o,
  input wire logic                        s_axi_rvalid_o,
  input wire logic                        s_axi_rready_i,
  input wire logic [NUM_PINS-1:0]         pad_in_i,
  input wire logic [NUM_PINS-1:0]         pad_oe_n_o,
  input wire gpp_pkg::gpp_pad_s [NUM_PINS-1:0] pad_cfg_o,
  input wire logic [NUM_PINS-1:0]         periph_in_o,
  input wire logic [NUM_PINS-1:0]         adc_trig_o,
  input wire logic                        irq_o
);
  logic [2:0]          run_q;
  logic [NUM_PINS-1:0] slew_bad, drv_bad, pup_v;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 3'h0;
    end else if (run_q != 3'h4) begin
      run_q <= run_q + 3'h1;
    end
  end
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      slew_bad[i] = pad_cfg_o[i].slew && (pad_cfg_o[i].drive != gpp_pkg::gpp_drv_8ma);
      drv_bad[i]  = pad_cfg_o[i].drive == gpp_pkg::gpp_drv_bad;
      pup_v[i]    = pad_cfg_o[i].pull_up;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wr_take_s;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence rd_take_s;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  wr_answer_a: assert property (wr_take_s |=> ##1 s_axi_bvalid_o && !s_axi_awready_o)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o &&
    $stable(s_axi_bresp_o)) else $error("write answer dropped");
  rd_answer_a: assert property (rd_take_s |=> s_axi_rvalid_o)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o &&
    $stable(s_axi_rdata_o)) else $error("read data dropped");
  slew_gate_a: assert property (slew_bad == '0)
    else $error("slew without 8 mA drive");
  drive_code_a: assert property (drv_bad == '0)
    else $error("illegal drive code");
  reset_state_a: assert property ($fell(rst_i) |-> &pad_oe_n_o && !irq_o &&
    adc_trig_o == '0 && pup_v == PUP_RESET[NUM_PINS-1:0]) else $error("bad reset state");
  sync_delay_a: assert property (run_q == 3'h4 |-> periph_in_o == $past(pad_in_i, 3))
    else $error("pin sync delay wrong");
endmodule // gpp_port_asserts

bind gpp_port gpp_port_asserts #(.NUM_PINS(NUM_PINS), .PUP_RESET(PUP_RESET)) i_gpp_asserts (
  .clk_i(clk_i), .rst_i(rst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bresp_o(s_axi_bresp_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rdata_o(s_axi_rdata_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .pad_in_i(pad_in_i), .pad_oe_n_o(pad_oe_n_o),
  .pad_cfg_o(pad_cfg_o), .periph_in_o(periph_in_o), .adc_trig_o(adc_trig_o), .irq_o(irq_o));

//--- testbench/testbench.sv
// Purpose: self-checking bench for the gpio port
// Assumes: board drives pin 0, other inputs float
// Notes:   watchdog cuts a hung handshake short
`timescale 1ns/1ps
`include "gpp_params.svh"
module testbench;
  logic              clk_i = 1'b0, rst_i = 1'b1;
  logic [11:0]       awaddr = 12'h000, araddr = 12'h000;
  logic [31:0]       wdata = 32'h0, rdata;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0, adc_seen = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]        bresp, rresp;
  logic [7:0]        pad_in, pad_out, pad_oe_n, periph_in, adc_trig;
  logic [7:0]        per_out = 8'h00, per_oe = 8'h10, ext_val = 8'h00;
  gpp_pkg::gpp_pad_s [7:0] pad_cfg;
  int                miscompares = 0, n_tests = 0;
  logic [2:0]        md [5] = '{3'h5, 3'h4, 3'h1, 3'h0, 3'h2};
  logic [4:0]        idle = 5'b01010, lvl = 5'b00011, back = 5'b10011;
  logic [11:0]       roff [8] = '{`GPP_OFF_DIR, `GPP_OFF_DRV, `GPP_OFF_SLEW, `GPP_OFF_ODRN,
                                  `GPP_OFF_PUP, `GPP_OFF_PDN, `GPP_OFF_PSEL, `GPP_OFF_ADC};
  gpp_port #(.NUM_PINS(8), .PUP_RESET(8'h00)) i_gpp_port (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .pad_in_i(pad_in), .pad_out_o(pad_out), .pad_oe_n_o(pad_oe_n), .pad_cfg_o(pad_cfg),
    .periph_out_i(per_out), .periph_oe_i(per_oe), .periph_in_o(periph_in),
    .adc_trig_o(adc_trig), .irq_o(irq));
  gpp_pin_model i_gpp_pin_model (
    .clk_i(clk_i), .pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n), .pad_cfg_i(pad_cfg),
    .ext_en_i(8'h01), .ext_val_i(ext_val), .pad_in_o(pad_in));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (adc_trig[0] === 1'b1) adc_seen <= 1'b1;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = `GPP_RESP_OKAY);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while ((awvalid && awready !== 1'b1) || (wvalid && wready !== 1'b1));
    @(posedge clk_i);
    bready <= 1'b1;
    do @(posedge clk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge clk_i); // let registered outputs settle
    check(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp,
                    input logic [1:0] er = `GPP_RESP_OKAY);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge clk_i);
    rready <= 1'b1;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata & m, exp);
    check(32'(rresp), 32'(er));
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'(pad_oe_n), 32'hff);
    foreach (roff[k]) rd(roff[k], '1, 32'h0);
    $display("reset test done");
    wr(`GPP_OFF_DIR, 32'hff);
    wr(12'h024, 32'hff);
    wr(12'h3c0, 32'h30);
    wr(12'h000, 32'hff);
    rd(12'h3fc, '1, 32'h39);
    rd(12'h03c, '1, 32'h09);
    check(32'(pad_out), 32'h39);
    check(32'(pad_oe_n), 32'h00);
    $display("data test done");
    wr(`GPP_OFF_ODRN, 32'h08);
    wr(`GPP_OFF_PSEL, 32'h10);
    check(32'(pad_out), 32'h21);
    check(32'(pad_oe_n), 32'h08);
    wr(`GPP_OFF_SLEW, 32'hff);
    wr(`GPP_OFF_DRV, 32'h36);
    check(32'(pad_cfg[2:0]), 32'h0114);
    wr(`GPP_OFF_PUP, 32'h01);
    check(32'(pad_cfg[0]), 32'h16);
    wr(`GPP_OFF_PDN, 32'h02);
    check(32'(pad_cfg[1]), 32'h09);
    wr(12'h600, 32'hff, `GPP_RESP_SLVE);
    rd(12'h600, '1, 32'h0, `GPP_RESP_SLVE);
    $display("pad test done");
    wr(`GPP_OFF_DIR, 32'h00);
    wr(`GPP_OFF_PSEL, 32'h00);
    for (int k = 0; k < 5; k++) begin
      ext_val <= {7'h0, idle[k]};
      wr(`GPP_OFF_SENSE, {24'h0, {8{md[k][2]}}});
      wr(`GPP_OFF_BOTH, {24'h0, {8{md[k][1]}}});
      wr(`GPP_OFF_EVHI, {24'h0, {8{md[k][0]}}});
      wr(`GPP_OFF_ICLR, 32'hff);
      rd(`GPP_OFF_RAW, 32'h1, 32'h0);
      ext_val <= {7'h0, ~idle[k]};
      repeat (5) @(posedge clk_i);
      rd(`GPP_OFF_RAW, 32'h1, 32'h1);
      wr(`GPP_OFF_ICLR, 32'h01);
      rd(`GPP_OFF_RAW, 32'h1, {31'h0, lvl[k]});
      ext_val <= {7'h0, idle[k]};
      repeat (5) @(posedge clk_i);
      rd(`GPP_OFF_RAW, 32'h1, {31'h0, back[k]});
    end
    $display("interrupt test done");
    wr(`GPP_OFF_ADC, 32'h01);
    wr(`GPP_OFF_ICLR, 32'hff);
    adc_seen = 1'b0;
    ext_val <= 8'h01;
    repeat (6) @(posedge clk_i);
    check(32'(irq), 32'h0);
    check(32'(adc_seen), 32'h1);
    rd(12'h004, '1, 32'h01);
    rd(`GPP_OFF_MSK, 32'hff, 32'h0);
    wr(`GPP_OFF_IEN, 32'h01);
    check(32'(irq), 32'h1);
    rd(`GPP_OFF_MSK, 32'hff, 32'h1);
    wr(`GPP_OFF_ICLR, 32'h01);
    check(32'(irq), 32'h0);
    wr(`GPP_OFF_ADC, 32'h00);
    adc_seen = 1'b0;
    ext_val <= 8'h00;
    repeat (5) @(posedge clk_i);
    check(32'(adc_seen), 32'h0);
    $display("trigger test done");
    test_done();
  end
endmodule // testbench
